// ### rwb_interlock.sv
// Rod withdrawal block interlock: two redundant block circuits fed by trip pins,
// bypass and outage control over AHB-Lite, permissives to the rod sequencer.
// Assumes all trip pins are asynchronous to hclk and the sequencer samples the
// permissive outputs on its own; only single word transfers reach the slave.
//
// Overview of operation
// - Two independent circuits, each own block output.
// - Permissive high only while movement allowed.
// - Block during withdrawal halts at next notch.
// - Refuelling interlock trips feed both circuits.
// - Shutdown mode blocks every withdrawal.
// - Any power monitor upscale or inoperative blocks.
// - Either rod block channel upscale/inoperative blocks.
// - Discharge volume high or trip bypassed blocks.
// - Pattern enforcer insert and withdraw blocks separate.
// - Position information malfunction blocks withdrawal.
// - Timer malfunction during withdrawal blocks.
// - Run mode: unbypassed power downscale blocks.
// - Run: rod block downscale, bypassed below 30%.
// - Startup/refuel: detector out, low count, low range.
// - Startup/refuel: source range alarms block.
// - Startup/refuel: intermediate detector not inserted blocks.
// - Startup/refuel: intermediate upscale blocks.
// - Startup/refuel: intermediate downscale blocks unless lowest range.
// - Startup/refuel: intermediate inoperative blocks.
// - Outage disable for detector position blocks.
// - Half the neutron channels feed each circuit.
// - Insert block keeps insert drive off.
`timescale 1ns/1ps
`default_nettype none

module rwb_interlock
  import rwb_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire rwb_pins_t   pins,
  output logic             withdraw_perm_a,
  output logic             withdraw_perm_b,
  output logic             withdraw_perm,
  output logic             insert_perm,
  output logic             halt_at_notch
);

  localparam int SRM_H = SRM_N / 2;
  localparam int IRM_H = IRM_N / 2;
  localparam int RBM_H = RBM_N / 2;

  rwb_state_t st_r;
  rwb_state_t st_nxt;
  rwb_pins_t  f;
  logic [APM_N-1:0] byp_apm;
  logic [RBM_N-1:0] byp_rbm;
  logic [SRM_N-1:0] byp_srm;
  logic [IRM_N-1:0] byp_irm;
  logic [1:0]       blk;

  assign f       = rwb_pins_t'(st_r.filt);
  assign byp_apm = st_r.bypass[BYP_APM_LSB +: APM_N];
  assign byp_rbm = st_r.bypass[BYP_RBM_LSB +: RBM_N];
  assign byp_srm = st_r.bypass[BYP_SRM_LSB +: SRM_N];
  assign byp_irm = st_r.bypass[BYP_IRM_LSB +: IRM_N];

  // ==========================================================
  // Block condition of one circuit
  // The power monitors and plant-wide trips reach both circuits; the
  // neutron channels are split so one dead circuit still leaves half.
  function automatic logic circuit_block(input rwb_pins_t p,
                                         input logic [RBM_H-1:0] rb_byp,
                                         input logic [SRM_H-1:0] sr_byp,
                                         input logic [IRM_H-1:0] ir_byp,
                                         input logic [RBM_H-1:0] rb_up,
                                         input logic [RBM_H-1:0] rb_dn,
                                         input logic [RBM_H-1:0] rb_inop,
                                         input logic [SRM_H-1:0] sr_up,
                                         input logic [SRM_H-1:0] sr_dn,
                                         input logic [SRM_H-1:0] sr_inop,
                                         input logic [SRM_H-1:0] sr_out,
                                         input logic [SRM_H-1:0] sr_low,
                                         input logic [IRM_H-1:0] ir_up,
                                         input logic [IRM_H-1:0] ir_dn,
                                         input logic [IRM_H-1:0] ir_inop,
                                         input logic [IRM_H-1:0] ir_out,
                                         input logic [IRM_H-1:0] ir_l2,
                                         input logic [IRM_H-1:0] ir_l1,
                                         input logic [APM_N-1:0] ap_byp,
                                         input logic             outage);
    logic any_mode;
    logic run_mode;
    logic low_mode;
    any_mode = 1'b0;
    run_mode = 1'b0;
    low_mode = 1'b0;
    any_mode = p.mode_shutdown;
    any_mode = any_mode | (|((p.apm_up | p.apm_inop) & ~ap_byp));
    any_mode = any_mode | (|((rb_up | rb_inop) & ~rb_byp));
    any_mode = any_mode | p.sdv_high | p.sdv_trip_bypassed;
    any_mode = any_mode | p.rpe_withdraw_blk | p.refuel_blk | p.rpis_fail;
    any_mode = any_mode | (p.timer_fail & p.withdraw_active);
    run_mode = (|(p.apm_dn & ~ap_byp)) | (~p.power_low & (|(rb_dn & ~rb_byp)));
    // source detector position with low counts on low range
    low_mode = ~outage & (|(sr_out & sr_low & ~sr_byp)) & (|(ir_l2 & ~ir_byp));
    low_mode = low_mode | (|((sr_up | sr_dn | sr_inop) & ~sr_byp));
    low_mode = low_mode | (~outage & (|(ir_out & ~ir_byp)));
    low_mode = low_mode | (|((ir_up | (ir_dn & ~ir_l1) | ir_inop) & ~ir_byp));
    return any_mode | (p.mode_run & run_mode)
           | ((p.mode_startup | p.mode_refuel) & low_mode);
  endfunction

  // ==========================================================
  // Two circuits
  always_comb begin
    blk = 2'b00;
    for (int c = 0; c < 2; c++) begin
      blk[c] = circuit_block(f, byp_rbm[c*RBM_H +: RBM_H], byp_srm[c*SRM_H +: SRM_H],
                             byp_irm[c*IRM_H +: IRM_H], f.rbm_up[c*RBM_H +: RBM_H],
                             f.rbm_dn[c*RBM_H +: RBM_H], f.rbm_inop[c*RBM_H +: RBM_H],
                             f.srm_up[c*SRM_H +: SRM_H], f.srm_dn[c*SRM_H +: SRM_H],
                             f.srm_inop[c*SRM_H +: SRM_H], f.srm_not_in[c*SRM_H +: SRM_H],
                             f.srm_below_permit[c*SRM_H +: SRM_H],
                             f.irm_up[c*IRM_H +: IRM_H], f.irm_dn[c*IRM_H +: IRM_H],
                             f.irm_inop[c*IRM_H +: IRM_H], f.irm_not_in[c*IRM_H +: IRM_H],
                             f.irm_low2[c*IRM_H +: IRM_H], f.irm_low1[c*IRM_H +: IRM_H],
                             byp_apm, st_r.outage);
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    // A pin counts only once the second and third stages agree, which
    // also rejects one-cycle glitches from contact bounce.
    st_nxt.s1   = PIN_W'(pins);
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));

    st_nxt.perm_a = ~blk[0];
    st_nxt.perm_b = ~blk[1];
    st_nxt.perm = ~blk[0] & ~blk[1];
    st_nxt.ins_perm = ~f.rpe_insert_blk;
    // The halt is held until the sequencer reports a notch, so a block that
    // clears again before the notch cannot let the rod run on.
    // halt at next notch; a new block wins over the notch clear
    st_nxt.halt = (st_r.halt & ~f.notch_reached) | ((|blk) & f.withdraw_active);

    // Zero wait states: write data lands one cycle after its address phase.
    st_nxt.readyout = 1'b1;
    st_nxt.wr_pend  = 1'b0;
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        OFS_BYPASS: st_nxt.bypass = hwdata[BYP_W-1:0];
        OFS_CTRL:   st_nxt.outage = hwdata[CTRL_OUTAGE];
        default:    st_nxt.bypass = st_r.bypass;
      endcase
    end
    if (hsel && htrans[1] && hready) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_addr = haddr[7:0];
      st_nxt.rdata   = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          OFS_BYPASS: st_nxt.rdata[BYP_W-1:0] = st_r.bypass;
          OFS_CTRL:   st_nxt.rdata[CTRL_OUTAGE] = st_r.outage;
          OFS_STAT: begin
            st_nxt.rdata[STAT_PERM_A] = st_r.perm_a;
            st_nxt.rdata[STAT_PERM_B] = st_r.perm_b;
            st_nxt.rdata[STAT_PERM]   = st_r.perm;
            st_nxt.rdata[STAT_INS]    = st_r.ins_perm;
            st_nxt.rdata[STAT_HALT]   = st_r.halt;
          end
          default: st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r          <= '0;
      st_r.readyout <= 1'b1;
      st_r.bypass   <= BYP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hrdata          = st_r.rdata;
  assign hreadyout       = st_r.readyout;
  assign hresp           = 1'b0;
  assign withdraw_perm_a = st_r.perm_a;
  assign withdraw_perm_b = st_r.perm_b;
  assign withdraw_perm   = st_r.perm;
  assign insert_perm     = st_r.ins_perm;
  assign halt_at_notch   = st_r.halt;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  shutdown_blk_a: assert property (
    f.mode_shutdown |=> !withdraw_perm_a && !withdraw_perm_b && !withdraw_perm)
    else $error("shutdown mode did not block both circuits");

  perm_and_a: assert property (
    withdraw_perm == (withdraw_perm_a && withdraw_perm_b))
    else $error("overall permissive high while a circuit blocks");

  apm_alarm_a: assert property (
    (|((f.apm_up | f.apm_inop) & ~byp_apm)) |=> !withdraw_perm_a && !withdraw_perm_b)
    else $error("power monitor alarm did not block");

  rbm_split_a: assert property (
    (f.rbm_up[0] && !byp_rbm[0]) |=> !withdraw_perm_a)
    else $error("rod block channel upscale did not block circuit A");

  sdv_level_a: assert property (
    (f.sdv_high || f.sdv_trip_bypassed) |=> !withdraw_perm_a && !withdraw_perm_b)
    else $error("discharge volume condition did not block");

  insert_blk_a: assert property (
    f.rpe_insert_blk |=> !insert_perm)
    else $error("insert block left insert drive permitted");

  run_down_a: assert property (
    (f.mode_run && (|(f.apm_dn & ~byp_apm))) |=> !withdraw_perm)
    else $error("run mode downscale did not block");

  irm_down_a: assert property (
    (f.mode_startup && f.irm_dn[0] && !f.irm_low1[0] && !byp_irm[0]) |=> !withdraw_perm_a)
    else $error("intermediate downscale off lowest range did not block");

  halt_notch_a: assert property (
    ((|blk) && f.withdraw_active) |=> halt_at_notch)
    else $error("block during withdrawal did not request notch halt");

  // ==========================================================
  // Checks of the plant-wide trips, rod block channel B and the insert drive
  // The plant-wide trips reach both circuits, so each circuit must drop on its own.
  rpe_withdraw_a: assert property (
    f.rpe_withdraw_blk |=> !withdraw_perm_a && !withdraw_perm_b)
    else $error("pattern enforcer withdraw block did not block");

  refuel_trip_a: assert property (
    f.refuel_blk |=> !withdraw_perm_a && !withdraw_perm_b)
    else $error("refuelling interlock trip did not block");

  rpis_fail_a: assert property (
    f.rpis_fail |=> !withdraw_perm_a && !withdraw_perm_b)
    else $error("position information malfunction did not block");

  timer_fail_a: assert property (
    (f.timer_fail && f.withdraw_active) |=> !withdraw_perm_a && !withdraw_perm_b)
    else $error("timer malfunction during withdrawal did not block");

  rbm_inop_b_a: assert property (
    (f.rbm_inop[1] && !byp_rbm[1]) |=> !withdraw_perm_b)
    else $error("rod block channel inoperative did not block circuit B");

  rbm_down_a: assert property (
    (f.mode_run && !f.power_low && f.rbm_dn[1] && !byp_rbm[1]) |=> !withdraw_perm_b)
    else $error("run mode rod block downscale did not block circuit B");

  insert_pass_a: assert property (
    !f.rpe_insert_blk |=> insert_perm)
    else $error("insert drive held off without an insert block");

  // ==========================================================
  // Checks of the startup and refuel trips
  // The detector position trips are masked while the outage disable is set.
  logic lo_mode;
  assign lo_mode = f.mode_startup | f.mode_refuel;

  srm_pos_a: assert property (
    (lo_mode && !st_r.outage && f.srm_not_in[0] && f.srm_below_permit[0] && !byp_srm[0]
     && (|(f.irm_low2[IRM_H-1:0] & ~byp_irm[IRM_H-1:0]))) |=> !withdraw_perm_a)
    else $error("source detector position trip did not block circuit A");

  srm_alarm_a: assert property (
    (lo_mode && (|((f.srm_up | f.srm_dn | f.srm_inop) & ~byp_srm))) |=> !withdraw_perm)
    else $error("source range alarm did not block");

  irm_pos_a: assert property (
    (lo_mode && !st_r.outage && (|(f.irm_not_in & ~byp_irm))) |=> !withdraw_perm)
    else $error("intermediate detector position trip did not block");

  irm_split_a: assert property (
    (lo_mode && !st_r.outage && f.irm_not_in[5] && !byp_irm[5]) |=> !withdraw_perm_b)
    else $error("upper intermediate channel did not block circuit B");

  irm_up_a: assert property (
    (lo_mode && (|(f.irm_up & ~byp_irm))) |=> !withdraw_perm)
    else $error("intermediate upscale did not block");

  irm_down_b_a: assert property (
    (lo_mode && f.irm_dn[6] && !f.irm_low1[6] && !byp_irm[6]) |=> !withdraw_perm_b)
    else $error("intermediate downscale off lowest range did not block circuit B");

  irm_inop_a: assert property (
    (lo_mode && (|(f.irm_inop & ~byp_irm))) |=> !withdraw_perm)
    else $error("intermediate inoperative did not block");

  // ==========================================================
  // Checks of the notch halt
  // The halt drops only on a notch with no fresh block during withdrawal.
  halt_clear_a: assert property (
    (halt_at_notch && f.notch_reached && !((|blk) && f.withdraw_active)) |=> !halt_at_notch)
    else $error("notch did not clear the halt request");

endmodule

`default_nettype wire

// ### rwb_interlock_bench.sv
// Self-checking bench of the rod withdrawal block interlock.
// Assumes a 200 MHz hclk, zero wait state AHB-Lite and a five edge pin path.
`timescale 1ns/1ps
`default_nettype none

module rwb_interlock_bench;
  import rwb_pkg::*;

  logic        hclk, hresetn, hsel, hwrite, go;
  logic [31:0] haddr, hwdata, hrdata, rd_v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, m_act, m_notch;
  logic        withdraw_perm_a, withdraw_perm_b, withdraw_perm, insert_perm, halt_at_notch;
  rwb_pins_t   p, q, pin_w;
  int          fails, checks;

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end

  always_comb begin
    pin_w = p;
    pin_w.withdraw_active = p.withdraw_active | m_act;
    pin_w.notch_reached = p.notch_reached | m_notch;
  end

  rwb_interlock i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pin_w),
    .withdraw_perm_a(withdraw_perm_a), .withdraw_perm_b(withdraw_perm_b),
    .withdraw_perm(withdraw_perm), .insert_perm(insert_perm),
    .halt_at_notch(halt_at_notch));

  rwb_seq_model i_seq (
    .hclk(hclk), .hresetn(hresetn), .go(go), .halt_at_notch(halt_at_notch),
    .withdraw_active(m_act), .notch_reached(m_notch));

  // ==========================================================
  // Bus and pin tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    `CHK(rd_v, e)
  endtask

  function automatic rwb_pins_t base(input int m);
    rwb_pins_t b;
    b = '0;
    case (m)
      0: b.mode_shutdown = 1'b1;
      1: b.mode_refuel = 1'b1;
      2: b.mode_startup = 1'b1;
      default: b.mode_run = 1'b1;
    endcase
    return b;
  endfunction

  // Seven edges cover the five edge pin path, the register update included.
  task automatic chk(input rwb_pins_t v, input logic ea, input logic eb);
    @(posedge hclk);
    p <= v;
    repeat (7) @(posedge hclk);
    #1;
    `CHK(withdraw_perm_a, ea)
    `CHK(withdraw_perm_b, eb)
    `CHK(withdraw_perm, ea & eb)
  endtask

  task automatic complete_run;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and test sequence
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    complete_run();
  end

  initial begin
    {hsel, hwrite, go, hresetn, fails, checks} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    p = '0;
    repeat (20) @(posedge hclk);
    `CHK(withdraw_perm, 1'b0)
    `CHK(hreadyout, 1'b1)
    `CHK(hresp, 1'b0)
    hresetn <= 1'b1;
    rd(OFS_BYPASS, 32'h00000000);
    rd(OFS_CTRL, 32'h00000000);
    rd(8'h0C, 32'h00000000);
    bus(1'b1, OFS_BYPASS, 32'hFFFFFFFF);
    rd(OFS_BYPASS, 32'h000FFFFF);
    bus(1'b1, OFS_BYPASS, 32'h00000000);
    chk(base(3), 1'b1, 1'b1);
    rd(OFS_STAT, 32'h0000000F);
    bus(1'b1, OFS_STAT, 32'h00000000);
    rd(OFS_STAT, 32'h0000000F);
    chk(base(0), 1'b0, 1'b0);
    q = base(3); q.apm_up[3] = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(2); q.apm_inop[5] = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(1); q.rbm_up[0] = 1'b1; chk(q, 1'b0, 1'b1);
    q = base(3); q.rbm_inop[1] = 1'b1; chk(q, 1'b1, 1'b0);
    q = base(3); q.sdv_high = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(2); q.sdv_trip_bypassed = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(3); q.rpe_withdraw_blk = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(3); q.rpe_insert_blk = 1'b1; chk(q, 1'b1, 1'b1);
    `CHK(insert_perm, 1'b0)
    rd(OFS_STAT, 32'h00000007);
    q = base(1); q.refuel_blk = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(3); q.rpis_fail = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(3); q.timer_fail = 1'b1; chk(q, 1'b1, 1'b1);
    q.withdraw_active = 1'b1; chk(q, 1'b0, 1'b0);
    `CHK(halt_at_notch, 1'b1)
    rd(OFS_STAT, 32'h00000018);
    q = base(3); q.notch_reached = 1'b1; chk(q, 1'b1, 1'b1);
    `CHK(halt_at_notch, 1'b0)
    q = base(3); q.apm_dn[0] = 1'b1; chk(q, 1'b0, 1'b0);
    q = base(2); q.apm_dn[0] = 1'b1; chk(q, 1'b1, 1'b1);
    q = base(3); q.rbm_dn[1] = 1'b1; chk(q, 1'b1, 1'b0);
    q.power_low = 1'b1; chk(q, 1'b1, 1'b1);
    q = base(2); q.srm_not_in[0] = 1'b1; q.srm_below_permit[0] = 1'b1;
    chk(q, 1'b1, 1'b1);
    q.irm_low2[1] = 1'b1; chk(q, 1'b0, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h00000001);
    chk(q, 1'b1, 1'b1);
    q = base(1); q.irm_not_in[5] = 1'b1; chk(q, 1'b1, 1'b1);
    bus(1'b1, OFS_CTRL, 32'h00000000);
    chk(q, 1'b1, 1'b0);
    q = base(2); q.srm_up[2] = 1'b1; chk(q, 1'b1, 1'b0);
    q = base(1); q.srm_dn[1] = 1'b1; chk(q, 1'b0, 1'b1);
    q = base(2); q.srm_inop[3] = 1'b1; chk(q, 1'b1, 1'b0);
    q = base(2); q.irm_up[0] = 1'b1; chk(q, 1'b0, 1'b1);
    q.mode_startup = 1'b0; q.mode_run = 1'b1; chk(q, 1'b1, 1'b1);
    q = base(1); q.irm_dn[6] = 1'b1; q.irm_low1[6] = 1'b1; chk(q, 1'b1, 1'b1);
    q.irm_low1[6] = 1'b0; chk(q, 1'b1, 1'b0);
    q = base(2); q.irm_inop[2] = 1'b1; chk(q, 1'b0, 1'b1);
    bus(1'b1, OFS_BYPASS, (32'h1 << (BYP_APM_LSB + 2)) | (32'h1 << (BYP_SRM_LSB + 1)));
    q = base(2); q.apm_up[2] = 1'b1; q.srm_up[1] = 1'b1; chk(q, 1'b1, 1'b1);
    bus(1'b1, OFS_BYPASS, 32'h1 << (BYP_RBM_LSB + 1));
    q = base(3); q.rbm_dn[1] = 1'b1; chk(q, 1'b1, 1'b1);
    chk(base(3), 1'b1, 1'b1);
    @(posedge hclk);
    go <= 1'b1;
    repeat (10) @(posedge hclk);
    p.sdv_high <= 1'b1;
    repeat (30) begin @(posedge hclk); if (halt_at_notch === 1'b1) break; end
    `CHK(halt_at_notch, 1'b1)
    go <= 1'b0;
    repeat (30) begin @(posedge hclk); if (m_act === 1'b0) break; end
    `CHK(m_act, 1'b0)
    complete_run();
  end
endmodule

`default_nettype wire

// ### rwb_pkg.sv
// Constants, pin bundle and state record of the rod withdrawal block interlock.
// Assumes a single 200 MHz clock domain and an AHB-Lite register bus.
package rwb_pkg;

  // ==========================================================
  // Channel counts
  localparam int APM_N = 6;
  localparam int RBM_N = 2;
  localparam int SRM_N = 4;
  localparam int IRM_N = 8;

  // ==========================================================
  // Register map and field positions
  localparam logic [7:0] OFS_BYPASS = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STAT   = 8'h08;
  localparam int BYP_APM_LSB  = 0;
  localparam int BYP_RBM_LSB  = 6;
  localparam int BYP_SRM_LSB  = 8;
  localparam int BYP_IRM_LSB  = 12;
  localparam int BYP_W        = 20;
  localparam int CTRL_OUTAGE  = 0;
  localparam int STAT_PERM_A  = 0;
  localparam int STAT_PERM_B  = 1;
  localparam int STAT_PERM    = 2;
  localparam int STAT_INS     = 3;
  localparam int STAT_HALT    = 4;
  localparam logic [BYP_W-1:0] BYP_RST = 20'h00000;

  // ==========================================================
  // Trip and status pins, all from outside the clock domain
  typedef struct packed {
    logic             mode_shutdown;
    logic             mode_refuel;
    logic             mode_startup;
    logic             mode_run;
    logic [APM_N-1:0] apm_up;
    logic [APM_N-1:0] apm_dn;
    logic [APM_N-1:0] apm_inop;
    logic [RBM_N-1:0] rbm_up;
    logic [RBM_N-1:0] rbm_dn;
    logic [RBM_N-1:0] rbm_inop;
    logic             power_low;
    logic [SRM_N-1:0] srm_up;
    logic [SRM_N-1:0] srm_dn;
    logic [SRM_N-1:0] srm_inop;
    logic [SRM_N-1:0] srm_not_in;
    logic [SRM_N-1:0] srm_below_permit;
    logic [IRM_N-1:0] irm_up;
    logic [IRM_N-1:0] irm_dn;
    logic [IRM_N-1:0] irm_inop;
    logic [IRM_N-1:0] irm_not_in;
    logic [IRM_N-1:0] irm_low2;
    logic [IRM_N-1:0] irm_low1;
    logic             sdv_high;
    logic             sdv_trip_bypassed;
    logic             rpe_insert_blk;
    logic             rpe_withdraw_blk;
    logic             refuel_blk;
    logic             rpis_fail;
    logic             timer_fail;
    logic             withdraw_active;
    logic             notch_reached;
  } rwb_pins_t;

  localparam int PIN_W = $bits(rwb_pins_t);

  // ==========================================================
  // Whole state of the block
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] filt;
    logic [BYP_W-1:0] bypass;
    logic             outage;
    logic             wr_pend;
    logic [7:0]       wr_addr;
    logic [31:0]      rdata;
    logic             readyout;
    logic             perm_a;
    logic             perm_b;
    logic             perm;
    logic             ins_perm;
    logic             halt;
  } rwb_state_t;

endpackage

// ### rwb_seq_model.sv
// Behavioural rod movement sequencer on the far side of the interlock.
// Assumes the bench pulses go to start a withdrawal; it stops at a notch once halted.
`timescale 1ns/1ps
`default_nettype none

module rwb_seq_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic go,
  input  wire logic halt_at_notch,
  output logic      withdraw_active,
  output logic      notch_reached
);
  logic [2:0] cnt_r;

  // ==========================================================
  // Notch timing
  // The notch flag stands two cycles so the pin filter never drops it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 3'h0;
      withdraw_active <= 1'b0;
      notch_reached <= 1'b0;
    end else begin
      cnt_r <= withdraw_active ? cnt_r + 3'h1 : 3'h0;
      notch_reached <= withdraw_active && (cnt_r >= 3'h6);
      if (notch_reached && halt_at_notch) begin
        withdraw_active <= 1'b0;
      end else if (go && !halt_at_notch) begin
        withdraw_active <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire
